// ===== logic/tcs_params.svh
/*
 * constants of the transmitter cadence sync front end.
 * assumes inclusion from the package only.
 */
`ifndef TCS_PARAMS_SVH
`define TCS_PARAMS_SVH

// ==========================================
// packet layout
`define TCS_PKT_LEN 188
`define TCS_SYNC_BYTE 8'h47
`define TCS_FILL_BYTE 8'hFF
`define TCS_HDR_LEN 4
// byte offsets from the sync byte
`define TCS_OFS_PID_HI 1
`define TCS_OFS_PID_LO 2
`define TCS_OFS_OPERATIONS_MESSAGE_TYPE 4
`define TCS_OFS_CADENCE 5
`define TCS_OFS_TRELLIS 6
// restored payload ranges, payload byte numbers counted from 1
`define TCS_FIX_A_LO 3
`define TCS_FIX_A_HI 14
`define TCS_FIX_B_LO 165
`define TCS_FIX_B_HI 184

// ==========================================
// sync timing
`define TCS_SEG_PER_FIELD 312
`define TCS_OM_PID 13'h1FFA
`define TCS_TCP_TYPE 8'h10

`endif

// ===== logic/tcs_pkg.sv
/*
 * types of the transmitter cadence sync front end.
 * assumes tcs_params.svh on the include path.
 */
`include "tcs_params.svh"

package tcs_pkg;

    typedef logic [7:0] tcs_byte_t;
    typedef logic [8:0] tcs_seg_t;
    typedef logic [7:0] tcs_pos_t;

    // lock state of the packet sync detector
    typedef enum logic [0:0] {
        TCS_HUNT = 1'b0,
        TCS_LOCK = 1'b1
    } tcs_lock_t;

endpackage

// ===== logic/tcs_cadence_sync.sv
/*
 * transmitter cadence sync front end: one-packet look-ahead delay, packet sync and
 * control packet detection, cadence countdown, field/frame sync marking, fixed payload
 * restoration and trellis state slaving.
 * assumes a byte stream synchronous to clk_sys_i and a downstream modulator that reads
 * the per-byte segment/field/frame marks and the trellis state outputs.
 */
// Behaviour
// RQ1: stream passes a 188-byte look-ahead delay, inspectable and modifiable.
// RQ2: detect 0x47 sync byte as it leaves the delay output.
// RQ3: each packet sync aligns segment sync, steps modulo-312 and modulo-2 counters.
// RQ4: control packet needs operations-message PID and this group's message type.
// RQ5: correctly placed control packet loads cadence pointer into a packet countdown.
// RQ6: countdown expiry resets modulo-312 and modulo-2 counters, starting a frame.
// RQ7: cadence sync point is treated as packet start and segment sync.
// RQ8: field and packet aligned functions realign to the cadence sync point.
// RQ9: frame sync segment, positive middle sequence, inserted at cadence sync point.
// RQ10: control packet check runs on every detected packet sync.
// RQ11: detector samples delay line at fixed offsets from the sync byte.
// RQ12: control packet fields are captured before any payload is overwritten.
// RQ13: payload bytes 3-14 and 165-184 of control packets become 0xFF.
// RQ14: restored bytes equal those the upstream adapter replaced.
// RQ15: restored control packets flow on like all other packets.
// RQ16: trellis state of each control packet is held in a latch.
// RQ17: at next field sync, current latched state loads the encoders.
// RQ18: 36-bit state goes out as twelve consecutive 3-bit groups.
// RQ19: input multiplexers on encoder storage select latched value over next state.
// RQ20: without current data encoders run on; used data is marked stale.
`timescale 1ns/10ps

module tcs_cadence_sync
    import tcs_pkg::*;
#(
    parameter int PKT_LEN = `TCS_PKT_LEN,
    parameter int SEGS = `TCS_SEG_PER_FIELD,
    parameter int ENCODERS = 12,
    parameter int STATE_BITS = 3
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // stream from the link
    input wire logic [7:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    // stream to data processing
    output logic [7:0] out_data_o,
    output logic out_seg_start_o,
    output logic out_field_sync_o,
    output logic out_frame_sync_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    // precoder and trellis encoder storage
    input wire logic [ENCODERS*STATE_BITS-1:0] enc_next_state_i,
    output logic [ENCODERS*STATE_BITS-1:0] enc_state_o,
    output logic enc_load_o
);

    localparam int SW = ENCODERS * STATE_BITS;
    localparam int TB = (SW + 7) / 8;
    localparam int OW = 11;

    // ==========================================
    // look-ahead delay line
    tcs_byte_t mem_r [PKT_LEN];
    tcs_pos_t wp_r;
    tcs_pos_t fill_r;
    logic full;
    logic adv;
    logic emit;

    function automatic tcs_pos_t la_idx(input tcs_pos_t base, input int ofs);
        int s;
        s = int'(base) + ofs;
        if (s >= PKT_LEN) begin
            s = s - PKT_LEN;
        end
        return tcs_pos_t'(s);
    endfunction

    assign full = (fill_r == tcs_pos_t'(PKT_LEN));
    assign adv = ce_i && in_valid_i && in_ready_o;
    assign emit = adv && full;

    always_ff @(posedge clk_sys_i) begin
        if (adv) begin
            mem_r[wp_r] <= in_data_i;  // see RQ1
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            wp_r <= '0;
            fill_r <= '0;
        end else if (adv) begin
            wp_r <= (wp_r == tcs_pos_t'(PKT_LEN - 1)) ? '0 : wp_r + 8'd1;
            if (!full) begin
                fill_r <= fill_r + 8'd1;
            end
        end
    end

    // ==========================================
    // packet sync and cadence detection
    tcs_byte_t cur;
    tcs_lock_t lock_r;
    tcs_pos_t pos_r;
    logic sync_hit;
    logic csp_hit;
    logic pkt_start;
    logic [12:0] la_pid;
    tcs_byte_t la_type;
    tcs_byte_t la_ptr;
    logic [TB*8-1:0] la_trellis;
    logic tcp_hit;

    assign cur = mem_r[wp_r];
    assign sync_hit = emit && (cur == `TCS_SYNC_BYTE)
        && (lock_r == TCS_HUNT || pos_r == tcs_pos_t'(PKT_LEN - 1));  // see RQ2

    assign la_pid = {mem_r[la_idx(wp_r, `TCS_OFS_PID_HI)][4:0],
                     mem_r[la_idx(wp_r, `TCS_OFS_PID_LO)]};  // see RQ11
    assign la_type = mem_r[la_idx(wp_r, `TCS_OFS_OPERATIONS_MESSAGE_TYPE)];
    assign la_ptr = mem_r[la_idx(wp_r, `TCS_OFS_CADENCE)];

    genvar gb;
    generate
        for (gb = 0; gb < TB; gb++) begin : g_tb
            assign la_trellis[TB*8-1-gb*8 -: 8] = mem_r[la_idx(wp_r, `TCS_OFS_TRELLIS + gb)];
        end
    endgenerate

    // whole packet sits in the delay line when its sync byte is at the output
    assign tcp_hit = pkt_start && (la_pid == `TCS_OM_PID)
        && (la_type == `TCS_TCP_TYPE);  // see RQ4, RQ10

    // cadence countdown
    logic cd_act_r;
    tcs_byte_t cd_cnt_r;

    assign csp_hit = emit && cd_act_r && (cd_cnt_r == 8'd0)
        && (lock_r == TCS_HUNT || pos_r == tcs_pos_t'(PKT_LEN - 1));  // see RQ6
    assign pkt_start = sync_hit || csp_hit;  // see RQ7

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            lock_r <= TCS_HUNT;
            pos_r <= '0;
        end else if (emit) begin
            if (pkt_start) begin
                lock_r <= TCS_LOCK;
                pos_r <= '0;  // see RQ8
            end else if (pos_r == tcs_pos_t'(PKT_LEN - 1)) begin
                lock_r <= TCS_HUNT;
                pos_r <= '0;
            end else begin
                pos_r <= pos_r + 8'd1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cd_act_r <= 1'b0;
            cd_cnt_r <= '0;
        end else if (pkt_start) begin
            if (tcp_hit) begin
                cd_act_r <= 1'b1;
                cd_cnt_r <= la_ptr;  // see RQ5, RQ12
            end else if (csp_hit) begin
                cd_act_r <= 1'b0;
            end else if (cd_act_r) begin
                cd_cnt_r <= cd_cnt_r - 8'd1;
            end
        end
    end

    // ==========================================
    // segment and field counters
    tcs_seg_t seg_r;
    logic fld_r;
    logic field_ev;
    logic frame_ev;

    assign field_ev = pkt_start && (csp_hit || seg_r == tcs_seg_t'(SEGS - 1));
    assign frame_ev = csp_hit || (field_ev && fld_r);  // see RQ9

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            seg_r <= '0;
            fld_r <= 1'b0;
        end else if (pkt_start) begin
            if (csp_hit) begin
                seg_r <= '0;  // see RQ6
                fld_r <= 1'b0;
            end else if (field_ev) begin
                seg_r <= '0;  // see RQ3
                fld_r <= ~fld_r;
            end else begin
                seg_r <= seg_r + 9'd1;
            end
        end
    end

    // ==========================================
    // fixed payload restoration
    logic tcp_pkt_r;
    logic restore;
    tcs_byte_t out_byte;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            tcp_pkt_r <= 1'b0;
        end else if (pkt_start) begin
            tcp_pkt_r <= tcp_hit;
        end
    end

    function automatic logic in_fix_next(input tcs_pos_t p);
        int n;
        n = int'(p) + 1 - `TCS_HDR_LEN + 1;
        return (n >= `TCS_FIX_A_LO && n <= `TCS_FIX_A_HI)
            || (n >= `TCS_FIX_B_LO && n <= `TCS_FIX_B_HI);
    endfunction

    // position after the step the output byte will hold
    assign restore = tcp_pkt_r && !pkt_start && (pos_r != tcs_pos_t'(PKT_LEN - 1))
        && in_fix_next(pos_r);
    assign out_byte = restore ? `TCS_FILL_BYTE : cur;  // see RQ13, RQ14, RQ15

    // ==========================================
    // trellis state latch and encoder loading
    logic [SW-1:0] ts_r;
    logic ts_cur_r;
    logic load;

    assign load = ce_i && field_ev && ts_cur_r;  // see RQ17
    assign enc_load_o = load;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ts_r <= '0;
            ts_cur_r <= 1'b0;
        end else if (ce_i && tcp_hit) begin
            ts_r <= la_trellis[TB*8-1 -: SW];  // see RQ16
            ts_cur_r <= 1'b1;
        end else if (load) begin
            ts_cur_r <= 1'b0;  // see RQ20
        end
    end

    genvar ge;
    generate
        for (ge = 0; ge < ENCODERS; ge++) begin : g_enc
            logic [STATE_BITS-1:0] st_r;
            logic [STATE_BITS-1:0] st_nxt;
            // group 0 takes the most significant bits
            assign st_nxt = load ? ts_r[SW-1-ge*STATE_BITS -: STATE_BITS]
                                 : enc_next_state_i[ge*STATE_BITS +: STATE_BITS];  // see RQ18, RQ19
            always_ff @(posedge clk_sys_i) begin
                if (srst_i) begin
                    st_r <= '0;
                end else if (ce_i) begin
                    st_r <= st_nxt;  // see RQ20
                end
            end
            assign enc_state_o[ge*STATE_BITS +: STATE_BITS] = st_r;
        end
    endgenerate

    // ==========================================
    // two-entry output buffer
    logic [OW-1:0] buf_r [2];
    logic [1:0] cnt_r;
    logic rd_ptr_r;
    logic wr_ptr_r;
    logic pop;
    logic [OW-1:0] ent;

    assign in_ready_o = !full || (cnt_r != 2'd2);
    assign pop = ce_i && out_valid_o && out_ready_i;
    assign ent = {out_byte, pkt_start, field_ev, frame_ev};

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cnt_r <= '0;
            rd_ptr_r <= 1'b0;
            wr_ptr_r <= 1'b0;
        end else begin
            if (emit) begin
                buf_r[wr_ptr_r] <= ent;
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            cnt_r <= cnt_r + {1'b0, emit} - {1'b0, pop};
        end
    end

    assign out_valid_o = (cnt_r != 2'd0);
    assign out_data_o = out_valid_o ? buf_r[rd_ptr_r][OW-1 -: 8] : 8'h00;
    assign out_seg_start_o = out_valid_o && buf_r[rd_ptr_r][2];
    assign out_field_sync_o = out_valid_o && buf_r[rd_ptr_r][1];
    assign out_frame_sync_o = out_valid_o && buf_r[rd_ptr_r][0];

endmodule

// ===== tb/tcs_tb_pkg.sv
/* source packet pattern shared by the upstream model and the bench.
   assumes packet 2 is the only control packet; packets 1 and 4 are decoys. */
package tcs_tb_pkg;

    // ========
    // byte b of packet p
    function automatic logic [7:0] src_byte(input int p, input int b);
        logic [39:0] trl;
        trl = 40'h12_3456_789A;
        if (b == 0) return 8'h47;
        if (p inside {1, 2, 4} && b == 1) return 8'h1F;
        if (p inside {1, 2, 4} && b == 2) return (p == 4) ? 8'hFB : 8'hFA;
        if (p inside {1, 2, 4} && b == 4) return (p == 1) ? 8'h11 : 8'h10;
        if (p == 2 && b == 5) return 8'h03;
        if (p == 2 && b >= 6 && b <= 10) return trl[8*(10-b)+:8];
        return {1'b1, b[6:0]};
    endfunction

endpackage

// ===== tb/tcs_upstream_model.sv
/* upstream adapter model: offers the packet stream one byte at a time.
   assumes the bench owns reset, enable and the run and slow controls. */
`timescale 1ns/10ps
module tcs_upstream_model
    import tcs_tb_pkg::*;
#(
    parameter int NBYTES = 188
) (
    // clock and controls
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic run_i,
    input wire logic slow_i,
    // stream to the device
    input wire logic ready_i,
    output logic [7:0] data_o,
    output logic valid_o,
    output int sent_o
);
    int cyc;
    logic taken;
    logic rst;

    // ========
    // offer, hold until taken, scramble while idle
    initial begin
        valid_o = 1'b0;
        data_o = 8'h00;
        sent_o = 0;
        cyc = 0;
        forever begin
            @(posedge clk_sys_i);
            rst = srst_i;
            taken = valid_o && ready_i && ce_i && !rst;
            sent_o = sent_o + int'(taken);
            cyc++;
            #1;
            if (rst) begin
                valid_o = 1'b0;
            end else if (!valid_o || taken) begin
                valid_o = run_i && sent_o < NBYTES && !(slow_i && cyc % 16 == 5);
                data_o = valid_o ? src_byte(sent_o / 188, sent_o % 188) : ~data_o;
            end
        end
    end
endmodule

// ===== tb/tcs_cadence_sync_properties.sv
/* port checks of the cadence sync front end.
   assumes binding into tcs_cadence_sync. */
`timescale 1ns/10ps
module tcs_cadence_sync_properties #(
    parameter int ENCODERS = 12,
    parameter int STATE_BITS = 3
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // streams
    input wire logic in_valid_i,
    input wire logic in_ready_o,
    input wire logic [7:0] out_data_o,
    input wire logic out_seg_start_o,
    input wire logic out_field_sync_o,
    input wire logic out_frame_sync_o,
    input wire logic out_valid_o,
    input wire logic out_ready_i,
    // encoder storage
    input wire logic [ENCODERS*STATE_BITS-1:0] enc_next_state_i,
    input wire logic [ENCODERS*STATE_BITS-1:0] enc_state_o,
    input wire logic enc_load_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    // ========
    // stream
    reset_clear_a:
        assert property (disable iff (1'b0) srst_i |=> !out_valid_o && enc_state_o == '0)
        else $error("reset left outputs active");
    hold_stall_a:
        assert property (out_valid_o && !(out_ready_i && ce_i) |=>
            out_valid_o && $stable(out_data_o) && $stable(out_frame_sync_o))
        else $error("stalled output changed");
    sync_byte_a:
        assert property (out_valid_o && out_seg_start_o && !out_frame_sync_o |-> out_data_o == 8'h47)
        else $error("segment start without sync byte");
    frame_mark_a:
        assert property (out_valid_o && out_frame_sync_o |-> out_field_sync_o && out_seg_start_o)
        else $error("frame sync without field sync and start");
    refuse_full_a:
        assert property (!in_ready_o |-> out_valid_o)
        else $error("input refused with empty buffer");

    // ========
    // encoder storage
    enc_next_a:
        assert property (ce_i && !enc_load_o |=> enc_state_o == $past(enc_next_state_i))
        else $error("encoder storage missed next state");
    enc_freeze_a:
        assert property (!ce_i |=> $stable(enc_state_o))
        else $error("encoder storage moved while disabled");
    load_on_push_a:
        assert property (enc_load_o |-> in_valid_i && in_ready_o && ce_i)
        else $error("load without byte push");
    load_once_a:
        assert property (enc_load_o |=> !enc_load_o [*8])
        else $error("latched state used twice");
endmodule

bind tcs_cadence_sync tcs_cadence_sync_properties #(
    .ENCODERS(ENCODERS),
    .STATE_BITS(STATE_BITS)
) tcs_cadence_sync_properties_inst (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce_i), .in_valid_i(in_valid_i),
    .in_ready_o(in_ready_o), .out_data_o(out_data_o), .out_seg_start_o(out_seg_start_o),
    .out_field_sync_o(out_field_sync_o), .out_frame_sync_o(out_frame_sync_o),
    .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
    .enc_next_state_i(enc_next_state_i), .enc_state_o(enc_state_o), .enc_load_o(enc_load_o)
);

// ===== tb/tcs_cadence_sync_tb_top.sv
/* bench: upstream model feeds 320 packets, a monitor checks every byte taken.
   assumes the checker is bound to the device. */
`timescale 1ns/10ps
module tcs_cadence_sync_tb_top
    import tcs_tb_pkg::*;
;
    localparam int C = 6;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce_hold = 1'b0, hold_out = 1'b0, stall_en = 1'b0, run = 1'b0, slow = 1'b0;
    int num_errors = 0, samples_checked = 0, k = 0, loads = 0, cyc = 0, sent, p, b, n;
    logic [35:0] st, enc_state_o;
    logic [7:0] in_data, out_data_o;
    logic in_valid, in_ready_o, out_seg_start_o, out_field_sync_o, out_frame_sync_o;
    logic out_valid_o, enc_load_o, fix;
    wire logic ce_i = !ce_hold;
    wire logic out_ready_i = !hold_out && !(stall_en && cyc % 16 == 0);

    tcs_upstream_model #(.NBYTES((C + 314) * 188)) tcs_upstream_model_inst (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce_i), .run_i(run), .slow_i(slow),
        .ready_i(in_ready_o), .data_o(in_data), .valid_o(in_valid), .sent_o(sent)
    );
    tcs_cadence_sync tcs_cadence_sync_inst (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce_i), .in_data_i(in_data),
        .in_valid_i(in_valid), .in_ready_o(in_ready_o), .out_data_o(out_data_o),
        .out_seg_start_o(out_seg_start_o), .out_field_sync_o(out_field_sync_o),
        .out_frame_sync_o(out_frame_sync_o), .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i), .enc_next_state_i({4'hA, cyc}),
        .enc_state_o(enc_state_o), .enc_load_o(enc_load_o)
    );

    // ========
    // clock, timeout, checks
    initial begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        #1;
        cyc++;
        if (cyc == 90000) begin
            num_errors++;
            results();
        end
    end
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ========
    // output monitor
    always @(posedge clk_sys_i) begin
        if (out_valid_o && out_ready_i && ce_i && !srst_i) begin
            p = k / 188;
            b = k % 188;
            fix = p == 2 && (b >= 6 && b <= 17 || b >= 168);
            chk("data", out_data_o, fix ? 8'hFF : src_byte(p, b));
            chk("segment start", out_seg_start_o, b == 0);
            if (p >= C && b == 0) begin
                chk("field sync", out_field_sync_o, p == C || p == C + 312);
                chk("frame sync", out_frame_sync_o, p == C);
            end
            k++;
        end
        if (enc_load_o) begin
            loads++;
            #1;
            chk("loaded state", enc_state_o, st);
        end
    end

    // ========
    // scenarios
    task automatic t_reset();
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk("ready in reset", in_ready_o, 1'b1);
        chk("valid in reset", out_valid_o, 1'b0);
        srst_i = 1'b0;
        $display("test reset done");
    endtask
    task automatic t_fill();
        run = 1'b1;
        for (int i = 0; i < 400 && sent < 188; i++) begin
            @(posedge clk_sys_i);
            #1;
        end
        chk("valid before full", out_valid_o, 1'b0);
        for (int i = 0; i < 20 && out_valid_o !== 1'b1; i++) #4;
        chk("bytes in at first out", sent, 189);
        $display("test fill done");
    endtask
    task automatic t_stall();
        hold_out = 1'b1;
        repeat (8) @(posedge clk_sys_i);
        #1;
        chk("refused when full", in_ready_o, 1'b0);
        n = sent;
        ce_hold = 1'b1;
        hold_out = 1'b0;
        repeat (4) @(posedge clk_sys_i);
        #1;
        chk("frozen by enable", sent, n);
        ce_hold = 1'b0;
        $display("test stall done");
    endtask
    task automatic t_stream();
        stall_en = 1'b1;
        slow = 1'b1;
        for (int i = 0; i < 90000 && k < (C + 313) * 188; i++) @(posedge clk_sys_i);
        #1;
        chk("state loads", loads, 1);
        $display("test stream done");
    endtask
    task automatic t_drain();
        run = 1'b0;
        stall_en = 1'b0;
        repeat (4) @(posedge clk_sys_i);
        #1;
        chk("drained", out_valid_o, 1'b0);
        chk("bytes out", k, sent - 188);
        $display("test drain done");
    endtask

    initial begin
        for (int g = 0; g < 12; g++) st[3*g+:3] = 3'((36'h1_2345_6789 >> (33 - 3 * g)));
        t_reset();
        t_fill();
        t_stall();
        t_stream();
        t_drain();
        results();
    end
endmodule
